/* design/ccs_pkg.sv */
package ccs_pkg;
  // Command codes.
  localparam logic [3:0] CMD_IDLE     = 4'h0;
  localparam logic [3:0] CMD_CONFIG   = 4'h1;
  localparam logic [3:0] CMD_RANDOM   = 4'h2;
  localparam logic [3:0] CMD_CRC      = 4'h3;
  localparam logic [3:0] CMD_TRANSMIT = 4'h4;
  localparam logic [3:0] CMD_KEEP     = 4'h7;
  localparam logic [3:0] CMD_RECEIVE  = 4'h8;
  localparam logic [3:0] CMD_SELF_CHECK_BIT = 4'h9;
  localparam logic [3:0] CMD_TRANSCV  = 4'hC;
  localparam logic [3:0] CMD_AUTOCOLL = 4'hD;
  localparam logic [3:0] CMD_AUTH     = 4'hE;
  localparam logic [3:0] CMD_SRESET   = 4'hF;
  // Register offsets (word index in the plain port).
  localparam logic [3:0] REG_COMMAND  = 4'h0;
  localparam logic [3:0] REG_FIFO     = 4'h1;
  localparam logic [3:0] REG_LEVEL    = 4'h2;
  localparam logic [3:0] REG_STATUS   = 4'h3;
  localparam logic [3:0] REG_MODE     = 4'h4;
  localparam logic [3:0] REG_FRAMING  = 4'h5;
  localparam logic [3:0] REG_RXMODE   = 4'h6;
  localparam logic [3:0] REG_CONTROL  = 4'h7;
  localparam logic [3:0] REG_AUTOTEST = 4'h8;
  localparam logic [3:0] REG_CRC_LO   = 4'h9;
  localparam logic [3:0] REG_CRC_HI   = 4'hA;
  // Field positions.
  localparam int CMD_RECEIVER_OFF_BIT_BIT  = 5;
  localparam int CMD_PDOWN_BIT   = 4;
  localparam int FRM_TRIGGER_BIT = 7;
  localparam int RXM_MULTI_BIT   = 2;
  localparam int CTL_INIT_BIT    = 4;
  localparam int AT_SELF_BIT     = 3;
  localparam int STS_DONE_BIT    = 0;
  // Buffer layout.
  localparam int CFG_BYTES       = 25;
  localparam int ID1_FIRST_IDX   = 2;
  localparam int ID1_CHECK_IDX   = 4;
  localparam int ID3_COUNT       = 10;
  localparam logic [7:0] ID1_FIRST_VAL = 8'h08;
  // FIFO depth.
  localparam int FIFO_DEPTH      = 64;
  // Self-test output length in bytes.
  localparam int SELF_BYTES      = 64;
  // CRC preset values by field code.
  localparam logic [15:0] CRC_PRESET0 = 16'h0000;
  localparam logic [15:0] CRC_PRESET1 = 16'h6363;
  localparam logic [15:0] CRC_PRESET2 = 16'hA671;
  localparam logic [15:0] CRC_PRESET3 = 16'hFFFF;
  localparam logic [15:0] CRC_POLY    = 16'h8408;
  localparam logic [15:0] LFSR_SEED   = 16'hACE1;
  // Sequencer states, one-hot.
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_CFGLD = 8'h02,
    ST_CFGRD = 8'h04,
    ST_RAND  = 8'h08,
    ST_CRC   = 8'h10,
    ST_TX    = 8'h20,
    ST_RX    = 8'h40,
    ST_EXT   = 8'h80
  } ccs_state_type;
endpackage

/* design/ccs_sequencer.sv */
`timescale 1ns/1ps
module ccs_sequencer (
  input  wire logic       ref_clk_i,       // System clock.
  input  wire logic       reset_i,         // Synchronous reset, active high.
  input  wire logic       hard_powerdown_pin_n_i, // Low holds logic in power-down.
  input  wire logic [3:0] addr_i,          // Register index.
  input  wire logic [7:0] wdata_i,         // Write data.
  input  wire logic       wr_i,            // Write strobe.
  input  wire logic       rd_i,            // Read strobe.
  output logic      [7:0] rdata_o,         // Read data, one cycle later.
  input  wire logic       frame_end_i,     // Receiver saw frame end.
  input  wire logic [7:0] rx_byte_i,       // Received byte.
  input  wire logic       rx_valid_i,      // Received byte strobe.
  output logic            tx_valid_o,      // Byte offered to transmitter.
  output logic      [7:0] tx_byte_o,       // Byte to transmit.
  input  wire logic       tx_ready_i,      // Transmitter takes byte.
  output logic            rx_enable_o,     // Receive path enabled.
  output logic            ext_active_o,    // Outside-block command running.
  output logic      [3:0] command_o        // Active command code.
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  // Power-down counts as reset for everything except the config buffer.
  logic rst;
  assign rst = reset_i | ~hard_powerdown_pin_n_i;

  ccs_pkg::ccs_state_type state_q;         // Sequencer state.
  logic [3:0]  cmd_q;                      // Active command code.
  logic [1:0]  cmd_misc_q;                 // Receiver-off and power-down bits.
  logic [7:0]  mode_q;                     // Mode register, preset in bits 1:0.
  logic [7:0]  framing_q;                  // Bit framing register.
  logic [7:0]  rxmode_q;                   // Receive mode register.
  logic [7:0]  control_q;                  // Control register.
  logic [7:0]  autotest_q;                 // Auto-test register.
  logic [15:0] crc_q;                      // CRC engine value.
  logic        done_q;                     // Command done flag.
  logic        rx_phase_q;                 // Transceive currently receiving.
  logic [15:0] lfsr_q;                     // Random source.
  logic [6:0]  idx_q;                      // Byte counter for sequences.
  logic [7:0]  chk_q;                      // Running check byte of first ident.
  logic [7:0]  cfg_mem [ccs_pkg::CFG_BYTES]; // Config buffer, not reset.

  // FIFO storage; the block owns it since commands move bytes both ways.
  logic [7:0]  fifo_mem [ccs_pkg::FIFO_DEPTH];
  logic [5:0]  wp_q;
  logic [5:0]  rp_q;
  logic [6:0]  cnt_q;

  ////////////////////////////////////////////////////////////////////////////
  // Decode.

  wire cmd_wr    = wr_i && addr_i == ccs_pkg::REG_COMMAND;
  wire [3:0] wcode = wdata_i[3:0];
  // Unassigned codes fall to idle so no odd state is reachable.
  wire code_known = wcode inside {ccs_pkg::CMD_IDLE, ccs_pkg::CMD_CONFIG,
                    ccs_pkg::CMD_RANDOM, ccs_pkg::CMD_CRC, ccs_pkg::CMD_TRANSMIT,
                    ccs_pkg::CMD_RECEIVE, ccs_pkg::CMD_SELF_CHECK_BIT, ccs_pkg::CMD_TRANSCV,
                    ccs_pkg::CMD_AUTOCOLL, ccs_pkg::CMD_AUTH, ccs_pkg::CMD_SRESET};
  wire new_cmd   = cmd_wr && wcode != ccs_pkg::CMD_KEEP;
  wire [3:0] eff_code = code_known ? wcode : ccs_pkg::CMD_IDLE;
  wire fifo_empty = cnt_q == 7'd0;
  wire fifo_full  = cnt_q == 7'(ccs_pkg::FIFO_DEPTH);
  wire multi      = rxmode_q[ccs_pkg::RXM_MULTI_BIT];
  wire trigger    = framing_q[ccs_pkg::FRM_TRIGGER_BIT];
  wire initiator  = control_q[ccs_pkg::CTL_INIT_BIT];
  wire self_check = autotest_q[ccs_pkg::AT_SELF_BIT];

  // Sending happens in transmit, and in transceive send phases after trigger.
  wire send_phase = (state_q == ccs_pkg::ST_TX) &&
                    (cmd_q == ccs_pkg::CMD_TRANSMIT || (!rx_phase_q && trigger));
  wire tx_take    = send_phase && !fifo_empty && tx_ready_i;

  // Which internal work or host access consumes or produces a FIFO byte this cycle.
  wire cfg_pop    = state_q == ccs_pkg::ST_CFGLD && !fifo_empty;
  wire crc_pop    = state_q == ccs_pkg::ST_CRC && !self_check && !fifo_empty;
  wire crc_push   = state_q == ccs_pkg::ST_CRC && self_check && !fifo_full &&
                    idx_q < 7'(ccs_pkg::SELF_BYTES);
  wire rd_push    = state_q == ccs_pkg::ST_CFGRD && !fifo_full;
  wire rx_push    = state_q == ccs_pkg::ST_RX && rx_valid_i && !fifo_full;
  wire host_push  = wr_i && addr_i == ccs_pkg::REG_FIFO && !fifo_full;
  wire host_pop   = rd_i && addr_i == ccs_pkg::REG_FIFO && !fifo_empty;
  wire pop        = cfg_pop | crc_pop | tx_take | host_pop;
  wire push       = rd_push | crc_push | rx_push | host_push;
  wire [7:0] head = fifo_mem[rp_q];
  wire [7:0] push_data = rd_push  ? cfg_mem[idx_q[4:0]] :
                         crc_push ? crc_q[7:0] ^ {1'b0, idx_q} :
                         rx_push  ? rx_byte_i : wdata_i;

  // Preset selection at command start.
  wire [15:0] preset = mode_q[1:0] == 2'd0 ? ccs_pkg::CRC_PRESET0 :
                       mode_q[1:0] == 2'd1 ? ccs_pkg::CRC_PRESET1 :
                       mode_q[1:0] == 2'd2 ? ccs_pkg::CRC_PRESET2 : ccs_pkg::CRC_PRESET3;

  // One byte through the CRC, bit serial, LSB first.
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int b = 0; b < 8; b++) begin
      r = r[0] ? ((r >> 1) ^ ccs_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state. Any code other than keep aborts the running command.

  ccs_pkg::ccs_state_type start_st;
  always_comb begin
    case (eff_code)
      ccs_pkg::CMD_CONFIG:   start_st = fifo_empty ? ccs_pkg::ST_CFGRD
                                                   : ccs_pkg::ST_CFGLD;
      ccs_pkg::CMD_RANDOM:   start_st = ccs_pkg::ST_RAND;
      ccs_pkg::CMD_CRC:      start_st = ccs_pkg::ST_CRC;
      ccs_pkg::CMD_TRANSMIT: start_st = ccs_pkg::ST_TX;
      ccs_pkg::CMD_RECEIVE:  start_st = ccs_pkg::ST_RX;
      ccs_pkg::CMD_TRANSCV:  start_st = initiator ? ccs_pkg::ST_TX
                                                  : ccs_pkg::ST_RX;
      ccs_pkg::CMD_SELF_CHECK_BIT, ccs_pkg::CMD_AUTOCOLL,
      ccs_pkg::CMD_AUTH, ccs_pkg::CMD_SRESET:
                             start_st = ccs_pkg::ST_EXT;
      default:               start_st = ccs_pkg::ST_IDLE;
    endcase
  end

  // Finishing conditions of the self-ending commands.
  wire tcv      = cmd_q == ccs_pkg::CMD_TRANSCV;
  wire cfg_fin  = (state_q == ccs_pkg::ST_CFGLD && idx_q == 7'(ccs_pkg::CFG_BYTES - 1) &&
                   cfg_pop) ||
                  (state_q == ccs_pkg::ST_CFGRD && idx_q == 7'(ccs_pkg::CFG_BYTES - 1) &&
                   rd_push);
  wire rand_fin = state_q == ccs_pkg::ST_RAND && idx_q == 7'(ccs_pkg::ID3_COUNT - 1);
  wire tx_fin   = state_q == ccs_pkg::ST_TX && !tcv && fifo_empty;
  wire rx_fin   = state_q == ccs_pkg::ST_RX && !tcv && frame_end_i && !multi;
  // Transceive has no finish term; only a new code ends it.
  wire finish   = cfg_fin | rand_fin | tx_fin | rx_fin;
  // Transceive phase switches; multi-frame keeps it receiving.
  wire tcv_to_rx = state_q == ccs_pkg::ST_TX && tcv && send_phase && fifo_empty;
  wire tcv_to_tx = state_q == ccs_pkg::ST_RX && tcv && frame_end_i && !multi;

  ccs_pkg::ccs_state_type state_d;
  always_comb begin
    state_d = state_q;
    if (new_cmd) begin
      state_d = start_st;
    end else if (finish) begin
      state_d = ccs_pkg::ST_IDLE;
    end else if (tcv_to_rx) begin
      state_d = ccs_pkg::ST_RX;
    end else if (tcv_to_tx) begin
      state_d = ccs_pkg::ST_TX;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer registers. The CRC command has no finish term.

  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      state_q    <= ccs_pkg::ST_IDLE;
      cmd_q      <= ccs_pkg::CMD_IDLE;
      cmd_misc_q <= 2'h0;
      rx_phase_q <= 1'b0;
      idx_q      <= 7'h00;
      chk_q      <= 8'h00;
    end else begin
      state_q <= state_d;
      if (cmd_wr) begin
        cmd_misc_q <= {wdata_i[ccs_pkg::CMD_RECEIVER_OFF_BIT_BIT], wdata_i[ccs_pkg::CMD_PDOWN_BIT]};
      end
      if (new_cmd) begin
        cmd_q <= eff_code;
        idx_q <= 7'h00;
        chk_q <= 8'h00;
      end else begin
        if (finish) begin
          cmd_q <= ccs_pkg::CMD_IDLE;
        end
        if (cfg_pop || rd_push || crc_push || state_q == ccs_pkg::ST_RAND) begin
          idx_q <= idx_q + 7'h01;
        end
      end
      rx_phase_q <= state_d == ccs_pkg::ST_RX;
      if (cfg_pop && idx_q > 7'(ccs_pkg::ID1_FIRST_IDX) && idx_q < 7'(ccs_pkg::ID1_CHECK_IDX)) begin
        chk_q <= chk_q ^ head;
      end
    end
  end

  // Config buffer has no reset so power-down keeps it.
  always_ff @(posedge ref_clk_i) begin
    if (cfg_pop) begin
      if (idx_q == 7'(ccs_pkg::ID1_FIRST_IDX)) begin
        cfg_mem[idx_q[4:0]] <= ccs_pkg::ID1_FIRST_VAL;
      end else if (idx_q == 7'(ccs_pkg::ID1_CHECK_IDX)) begin
        cfg_mem[idx_q[4:0]] <= chk_q ^ ccs_pkg::ID1_FIRST_VAL;
      end else begin
        cfg_mem[idx_q[4:0]] <= head;
      end
    end else if (state_q == ccs_pkg::ST_RAND && !new_cmd && !rst) begin
      // Third ident spans first ident, second ident and last byte.
      if (idx_q < 7'd3) begin
        cfg_mem[5'(idx_q + 7'd2)] <= lfsr_q[7:0];
      end else if (idx_q < 7'd9) begin
        cfg_mem[5'(idx_q + 7'd5)] <= lfsr_q[7:0];
      end else begin
        cfg_mem[5'(ccs_pkg::CFG_BYTES - 1)] <= lfsr_q[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // FIFO; command start never clears it.

  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      wp_q  <= 6'h00;
      rp_q  <= 6'h00;
      cnt_q <= 7'h00;
    end else begin
      if (push) begin
        wp_q <= wp_q + 6'h01;
      end
      if (pop) begin
        rp_q <= rp_q + 6'h01;
      end
      cnt_q <= cnt_q + 7'(push) - 7'(pop);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      fifo_mem[wp_q] <= push_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CRC, random source, settings and done flag.

  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      crc_q      <= 16'h0000;
      lfsr_q     <= ccs_pkg::LFSR_SEED;
      mode_q     <= 8'h00;
      framing_q  <= 8'h00;
      rxmode_q   <= 8'h00;
      control_q  <= 8'h00;
      autotest_q <= 8'h00;
      done_q     <= 1'b0;
    end else begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      if (new_cmd && eff_code == ccs_pkg::CMD_CRC) begin
        crc_q <= preset;
      end else if (crc_pop) begin
        crc_q <= crc_step(crc_q, head);
      end else if (crc_push) begin
        crc_q <= crc_step(crc_q, {1'b0, idx_q});
      end
      if (wr_i && addr_i == ccs_pkg::REG_MODE)     mode_q     <= wdata_i;
      if (wr_i && addr_i == ccs_pkg::REG_RXMODE)   rxmode_q   <= wdata_i;
      if (wr_i && addr_i == ccs_pkg::REG_CONTROL)  control_q  <= wdata_i;
      if (wr_i && addr_i == ccs_pkg::REG_AUTOTEST) autotest_q <= wdata_i;
      if (wr_i && addr_i == ccs_pkg::REG_FRAMING) begin
        framing_q <= wdata_i;
      end else if (tcv_to_rx) begin
        // Trigger is consumed by each sent frame, so each needs a new one.
        framing_q[ccs_pkg::FRM_TRIGGER_BIT] <= 1'b0;
      end
      // Set wins over a same-cycle clear by writing 1.
      if (finish) begin
        done_q <= 1'b1;
      end else if (wr_i && addr_i == ccs_pkg::REG_STATUS && wdata_i[ccs_pkg::STS_DONE_BIT]) begin
        done_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port and outputs.

  logic [7:0] rd_mux;
  always_comb begin
    case (addr_i)
      ccs_pkg::REG_COMMAND:  rd_mux = {2'b00, cmd_misc_q, cmd_q};
      ccs_pkg::REG_FIFO:     rd_mux = head;
      ccs_pkg::REG_LEVEL:    rd_mux = {1'b0, cnt_q};
      ccs_pkg::REG_STATUS:   rd_mux = {7'h00, done_q};
      ccs_pkg::REG_MODE:     rd_mux = mode_q;
      ccs_pkg::REG_FRAMING:  rd_mux = framing_q;
      ccs_pkg::REG_RXMODE:   rd_mux = rxmode_q;
      ccs_pkg::REG_CONTROL:  rd_mux = control_q;
      ccs_pkg::REG_AUTOTEST: rd_mux = autotest_q;
      ccs_pkg::REG_CRC_LO:   rd_mux = crc_q[7:0];
      ccs_pkg::REG_CRC_HI:   rd_mux = crc_q[15:8];
      default:               rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rd_i ? rd_mux : 8'h00;
    end
  end

  assign tx_valid_o   = send_phase && !fifo_empty;
  assign tx_byte_o    = head;
  assign rx_enable_o  = state_q == ccs_pkg::ST_RX && !cmd_misc_q[1];
  assign ext_active_o = state_q == ccs_pkg::ST_EXT;
  assign command_o    = cmd_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_idle_cancel;
    @(posedge ref_clk_i) disable iff (rst)
      new_cmd && eff_code == ccs_pkg::CMD_IDLE |=> state_q == ccs_pkg::ST_IDLE;
  endproperty
  a_idle_cancel: assert property (p_idle_cancel) else $error("idle did not cancel");

  property p_keep;
    @(posedge ref_clk_i) disable iff (rst)
      cmd_wr && wcode == ccs_pkg::CMD_KEEP && !finish |=> $stable(cmd_q);
  endproperty
  a_keep: assert property (p_keep) else $error("keep code changed command");

  property p_done;
    @(posedge ref_clk_i) disable iff (rst)
      finish && !new_cmd |=> done_q && cmd_q == ccs_pkg::CMD_IDLE;
  endproperty
  a_done: assert property (p_done) else $error("finish without done flag");

  property p_crc_runs;
    @(posedge ref_clk_i) disable iff (rst)
      state_q == ccs_pkg::ST_CRC && !new_cmd |=> state_q == ccs_pkg::ST_CRC;
  endproperty
  a_crc_runs: assert property (p_crc_runs) else $error("crc ended itself");

  property p_tx_end;
    @(posedge ref_clk_i) disable iff (rst)
      state_q == ccs_pkg::ST_TX && cmd_q == ccs_pkg::CMD_TRANSMIT && fifo_empty && !new_cmd
      |=> state_q == ccs_pkg::ST_IDLE;
  endproperty
  a_tx_end: assert property (p_tx_end) else $error("transmit did not end");

  property p_multi;
    @(posedge ref_clk_i) disable iff (rst)
      state_q == ccs_pkg::ST_RX && multi && !new_cmd |=> state_q == ccs_pkg::ST_RX;
  endproperty
  a_multi: assert property (p_multi) else $error("multi receive left");

  property p_trigger;
    @(posedge ref_clk_i) disable iff (rst)
      tcv && !trigger |-> !tx_valid_o;
  endproperty
  a_trigger: assert property (p_trigger) else $error("sent without trigger");

  property p_preset;
    @(posedge ref_clk_i) disable iff (rst)
      new_cmd && eff_code == ccs_pkg::CMD_CRC |=> crc_q == $past(preset);
  endproperty
  a_preset: assert property (p_preset) else $error("crc preset wrong");

  property p_cfg_len;
    @(posedge ref_clk_i) disable iff (rst)
      new_cmd && start_st == ccs_pkg::ST_CFGRD && ccs_pkg::FIFO_DEPTH >= 25
      |=> ##25 state_q == ccs_pkg::ST_IDLE;
  endproperty
  a_cfg_len: assert property (p_cfg_len) else $error("readback length wrong");

  c_cfg:  cover property (@(posedge ref_clk_i) state_q == ccs_pkg::ST_CFGLD ##1 cfg_fin);
  c_rand: cover property (@(posedge ref_clk_i) rand_fin);
  c_tcv:  cover property (@(posedge ref_clk_i) tcv_to_rx ##[1:50] tcv_to_tx);
  c_crc:  cover property (@(posedge ref_clk_i) crc_pop);

endmodule

/* verif/ccs_radio_model.sv */
`timescale 1ns/1ps
// Front-end stand-in: takes transmit bytes with random stalls, and on a
// request sends three bytes and then a frame end pulse.
module ccs_radio_model (
  input  wire logic       clk_i,       // System clock.
  input  wire logic       frame_req_i, // Pulse: send one short frame.
  input  wire logic       tx_valid_i,  // Byte offered by the sequencer.
  output logic            tx_ready_o,  // Byte taken.
  output logic      [7:0] rx_byte_o,   // Received byte.
  output logic            rx_valid_o,  // Received byte strobe.
  output logic            frame_end_o  // End of the frame.
);
  int cnt = 0; // Frame step counter.
  initial begin
    tx_ready_o = 1'b0;
    rx_byte_o = 8'h00;
    rx_valid_o = 1'b0;
    frame_end_o = 1'b0;
  end
  // Random stalls test slow takers; idle data toggles so it is never stale.
  always @(posedge clk_i) begin
    tx_ready_o <= tx_valid_i & 1'($urandom);
    rx_valid_o <= (cnt > 1);
    rx_byte_o <= (cnt > 1) ? 8'(cnt) : ~rx_byte_o;
    frame_end_o <= (cnt == 1);
    cnt <= frame_req_i ? 4 : (cnt > 0 ? cnt - 1 : 0);
  end
endmodule

/* verif/tb_ccs_sequencer.sv */
`timescale 1ns/1ps
module tb_ccs_sequencer;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       pd_n = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       freq = 1'b0;
  logic [7:0] rdata, tx_byte, rx_byte, rv;
  logic       tx_valid, tx_ready, rx_valid, frame_end, rx_en, ext;
  logic [3:0] cmd;
  int         n_mismatch = 0;
  int         compares = 0;
  int         nchg;
  logic [15:0] crc;
  logic [7:0] cfg[25];
  logic [7:0] sent[$];
  logic [7:0] exp_q[$];
  logic [3:0] codes[4] = '{4'h9, 4'hD, 4'hE, 4'hF};
  // The 125 MHz clock.
  always #4 clk = ~clk;
  ccs_sequencer u_ccs_sequencer (.ref_clk_i(clk), .reset_i(rst), .hard_powerdown_pin_n_i(pd_n),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .frame_end_i(frame_end), .rx_byte_i(rx_byte), .rx_valid_i(rx_valid),
    .tx_valid_o(tx_valid), .tx_byte_o(tx_byte), .tx_ready_i(tx_ready),
    .rx_enable_o(rx_en), .ext_active_o(ext), .command_o(cmd));
  ccs_radio_model u_ccs_radio_model (.clk_i(clk), .frame_req_i(freq), .tx_valid_i(tx_valid),
    .tx_ready_o(tx_ready), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid),
    .frame_end_o(frame_end));
  // Bytes the transmitter really took.
  always @(posedge clk) if (tx_valid && tx_ready) sent.push_back(tx_byte);
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Reference checksum step, reflected, from the package polynomial.
  function automatic logic [15:0] crc_ref(logic [15:0] c, logic [7:0] d);
    c = c ^ {8'h00, d};
    for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ ccs_pkg::CRC_POLY) : (c >> 1);
    return c;
  endfunction
  task automatic wr_reg(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd_reg(logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    rv = rdata;
  endtask
  task automatic wait_idle(int lim);
    // Look at the falling edge, so the code written at the last edge has landed.
    @(negedge clk);
    for (int i = 0; i < lim && cmd !== 4'h0; i++) @(negedge clk);
    chk("command", 8'h00, {4'h0, cmd});
  endtask
  task automatic complete_run;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog, far beyond the expected run.
  initial begin
    #200000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h4345ecf5));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("reset command", 8'h00, {4'h0, cmd});
    // Load an image with the fixed polling prefix; check byte slot left zero.
    foreach (cfg[i]) begin
      cfg[i] = (i == 6) ? 8'h01 : (i == 7) ? 8'hFE : (i == 4) ? 8'h00 : 8'($urandom);
      wr_reg(ccs_pkg::REG_FIFO, cfg[i]);
    end
    wr_reg(ccs_pkg::REG_COMMAND, {4'h0, ccs_pkg::CMD_CONFIG});
    wait_idle(60);
    rd_reg(ccs_pkg::REG_LEVEL);
    chk("level", 8'h00, rv);
    rd_reg(ccs_pkg::REG_STATUS);
    chk("done", 8'h01, {7'h0, rv[0]});
    wr_reg(ccs_pkg::REG_STATUS, 8'h01);
    // Hard power-down must not touch the stored image.
    pd_n <= 1'b0;
    repeat (3) @(posedge clk);
    pd_n <= 1'b1;
    cfg[2] = 8'h08;
    cfg[4] = 8'h08 ^ cfg[3];
    wr_reg(ccs_pkg::REG_COMMAND, {4'h0, ccs_pkg::CMD_CONFIG});
    wait_idle(60);
    foreach (cfg[i]) begin
      rd_reg(ccs_pkg::REG_FIFO);
      chk("readback", cfg[i], rv);
    end
    // A fresh random ident leaves every byte outside the third ident alone.
    wr_reg(ccs_pkg::REG_COMMAND, {4'h0, ccs_pkg::CMD_RANDOM});
    wait_idle(20);
    wr_reg(ccs_pkg::REG_COMMAND, {4'h0, ccs_pkg::CMD_CONFIG});
    wait_idle(60);
    nchg = 0;
    foreach (cfg[i]) begin
      rd_reg(ccs_pkg::REG_FIFO);
      if (i inside {[2:4], [8:13], 24}) nchg += (rv != cfg[i]);
      else chk("kept byte", cfg[i], rv);
    end
    chk("ident changed", 8'h01, {7'h0, nchg > 4});
    // Bytes written before the start are sent, then the command ends.
    sent.delete();
    repeat (5) begin
      exp_q.push_back(8'($urandom));
      wr_reg(ccs_pkg::REG_FIFO, exp_q[$]);
    end
    wr_reg(ccs_pkg::REG_COMMAND, {4'h0, ccs_pkg::CMD_TRANSMIT});
    wait_idle(200);
    chk("tx count", 8'd5, 8'(sent.size()));
    foreach (exp_q[i]) chk("tx byte", exp_q[i], sent[i]);
    // The checksum command runs on; keep code and unknown code.
    wr_reg(ccs_pkg::REG_MODE, 8'h03);
    wr_reg(ccs_pkg::REG_COMMAND, {4'h0, ccs_pkg::CMD_CRC});
    crc = ccs_pkg::CRC_PRESET3;
    // Bytes arrive after the FIFO ran dry; they must still be folded in.
    repeat (3) begin
      rv = 8'($urandom);
      crc = crc_ref(crc, rv);
      wr_reg(ccs_pkg::REG_FIFO, rv);
    end
    repeat (40) @(posedge clk);
    chk("crc runs", 8'h03, {4'h0, cmd});
    rd_reg(ccs_pkg::REG_CRC_LO);
    chk("crc low", crc[7:0], rv);
    rd_reg(ccs_pkg::REG_CRC_HI);
    chk("crc high", crc[15:8], rv);
    wr_reg(ccs_pkg::REG_COMMAND, {4'h2, ccs_pkg::CMD_KEEP});
    @(negedge clk);
    chk("keep", 8'h03, {4'h0, cmd});
    rd_reg(ccs_pkg::REG_COMMAND);
    chk("keep other bits", 8'h23, rv);
    wr_reg(ccs_pkg::REG_COMMAND, 8'h05);
    wait_idle(3);
    // Single-frame receive ends at frame end; multi-frame does not.
    for (int m = 0; m < 2; m++) begin
      wr_reg(ccs_pkg::REG_RXMODE, 8'(m << 2));
      wr_reg(ccs_pkg::REG_COMMAND, {4'h0, ccs_pkg::CMD_RECEIVE});
      @(negedge clk);
      chk("rx enable", 8'h01, {7'h0, rx_en});
      @(posedge clk);
      freq <= 1'b1;
      @(posedge clk);
      freq <= 1'b0;
      repeat (10) @(posedge clk);
      chk("rx end", m ? 8'h08 : 8'h00, {4'h0, cmd});
      // The far side sends its step count as data: 4, 3, then 2.
      for (int j = 4; j > 1; j--) begin
        rd_reg(ccs_pkg::REG_FIFO);
        chk("rx byte", 8'(j), rv);
      end
    end
    wr_reg(ccs_pkg::REG_RXMODE, 8'h00);
    // Initiator: send waits for the trigger, then the receiver opens.
    wr_reg(ccs_pkg::REG_CONTROL, 8'h10);
    wr_reg(ccs_pkg::REG_FIFO, 8'h5A);
    wr_reg(ccs_pkg::REG_COMMAND, {4'h0, ccs_pkg::CMD_TRANSCV});
    repeat (5) @(posedge clk);
    chk("held send", 8'h00, {6'h0, rx_en, tx_valid});
    wr_reg(ccs_pkg::REG_FRAMING, 8'h80);
    repeat (80) @(posedge clk);
    chk("rx after send", 8'h01, {7'h0, rx_en});
    chk("transceive runs", 8'h0C, {4'h0, cmd});
    // Target: receive comes first.
    wr_reg(ccs_pkg::REG_CONTROL, 8'h00);
    wr_reg(ccs_pkg::REG_COMMAND, {4'h0, ccs_pkg::CMD_IDLE});
    wr_reg(ccs_pkg::REG_COMMAND, {4'h0, ccs_pkg::CMD_TRANSCV});
    @(negedge clk);
    chk("target rx", 8'h01, {7'h0, rx_en});
    wr_reg(ccs_pkg::REG_COMMAND, {4'h0, ccs_pkg::CMD_IDLE});
    wait_idle(3);
    // Outside-block codes are recognised by the decoder.
    foreach (codes[k]) begin
      wr_reg(ccs_pkg::REG_COMMAND, {4'h0, codes[k]});
      @(negedge clk);
      chk("ext active", 8'h01, {7'h0, ext});
      wr_reg(ccs_pkg::REG_COMMAND, 8'h00);
    end
    // Self-check mode fills the empty FIFO with its result block.
    wr_reg(ccs_pkg::REG_AUTOTEST, 8'h08);
    wr_reg(ccs_pkg::REG_COMMAND, {4'h0, ccs_pkg::CMD_CRC});
    repeat (80) @(posedge clk);
    rd_reg(ccs_pkg::REG_LEVEL);
    chk("self-test bytes", 8'(ccs_pkg::SELF_BYTES), rv);
    complete_run();
  end
endmodule
